// ==== logic/buf_irq_pkg.sv ====
// Package: register map, field layout and reset values of the buffer interrupt gating block
package buf_irq_pkg;
  // Register word byte addresses on the bus
  localparam logic [7:0] TXB_EN_ADDR  = 8'h00;
  localparam logic [7:0] BUF_EN_ADDR  = 8'h04;
  localparam logic [7:0] PIE_ADDR     = 8'h08;
  localparam logic [7:0] FLAG_ADDR    = 8'h0C;
  localparam logic [7:0] MODE_ADDR    = 8'h10;
  localparam logic [7:0] STAT_ADDR    = 8'h14;
  localparam logic [7:0] MASK_ADDR    = 8'h18;
  // Field layout
  localparam logic [7:0] TXB_EN_MASK  = 8'h1C;
  localparam int         TXB_EN_LSB   = 2;
  localparam int         PIE_TX_BIT   = 4;
  localparam int         PIE_RX_BIT   = 1;
  localparam int         FLAG_TX_BIT  = 4;
  localparam int         FLAG_RX_BIT  = 1;
  localparam logic [7:0] PIE_MASK     = 8'h12;
  localparam int         NUM_TXB      = 3;
  localparam int         NUM_BUF      = 8;
  localparam logic [1:0] MODE_LEGACY  = 2'h0;
  localparam logic [1:0] MODE_FIFO    = 2'h1;
  localparam logic [1:0] MODE_ENH     = 2'h2;
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [1:0] MODE_RESET   = 2'h0;
  localparam logic [1:0] STAT_RESET   = 2'h0;
endpackage

// ==== logic/buf_irq_gate.sv ====
// Per-buffer interrupt enable gating with a classic Wishbone register slave
// ====================================================================
// Notes on behaviour
// - Both enable registers exist and act only in modes 1 and 2.
// - Transmit enable bits 4..2 enable transmit buffers 2..0.
// - Transmit enable bits 7..5 and 1..0 read zero, ignore writes.
// - Transmit buffer interrupt at CPU_IRQ also needs the group transmit enable.
// - Buffer enable bits 7..2 enable programmable buffers 5..0.
// - Buffer enable bits 1..0 enable dedicated receive buffers 1..0.
// - Buffer enable interrupt at CPU_IRQ needs group transmit or group receive enable.
// - Implemented enable bits are read/write and reset to zero.
// - Group transmit enable gates all transmit buffer interrupts at CPU_IRQ in modes 1, 2.
// - Group transmit flag sets when any enabled transmit buffer completes.
// - Group receive flag sets when any enabled receive buffer receives.
`timescale 1ns/1ps
module buf_irq_gate (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        CE,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic [2:0]  TXB_DONE,
  input  wire logic [7:0]  BUF_EVENT,
  input  wire logic [7:0]  BUF_IS_TX,
  output logic             CPU_IRQ,
  output logic             IRQ
);

  // ====================================================================
  // Register state
  logic [7:0]  tx_buffer_irq_enable_reg, tx_buffer_irq_enable_next;
  logic [7:0]  buffer_irq_enable_reg,    buffer_irq_enable_next;
  logic [7:0]  periph_irq_enable_reg,    periph_irq_enable_next;
  logic [7:0]  periph_irq_flag_reg,      periph_irq_flag_next;
  logic [1:0]  mode_reg,                 mode_next;
  logic [1:0]  stat_reg,                 stat_next;
  logic [1:0]  mask_reg,                 mask_next;
  logic        ack_reg,                  ack_next;
  logic [31:0] dat_reg,                  dat_next;

  logic        enhanced;
  logic        access;
  logic        wr;
  logic        clr_tx_flag;
  logic        clr_rx_flag;
  logic [2:0]  tx_buf_irq_en_bits;
  logic [5:0]  prog_buf_irq_en_bits;
  logic [1:0]  dedicated_rx_irq_en_bits;
  logic [2:0]  txb_hit;
  logic [7:0]  buf_tx_hit;
  logic [7:0]  buf_rx_hit;
  logic        tx_event;
  logic        rx_event;
  logic        group_tx_irq_en;
  logic        group_rx_irq_en;
  logic        group_tx_irq_flag;
  logic        group_rx_irq_flag;

  // ====================================================================
  // Event gating
  // Enhanced modes only
  assign enhanced = (mode_reg == buf_irq_pkg::MODE_FIFO) || (mode_reg == buf_irq_pkg::MODE_ENH);

  assign tx_buf_irq_en_bits       = tx_buffer_irq_enable_reg[4:2];
  assign prog_buf_irq_en_bits     = buffer_irq_enable_reg[7:2];
  assign dedicated_rx_irq_en_bits = buffer_irq_enable_reg[1:0];
  assign group_tx_irq_en          = periph_irq_enable_reg[buf_irq_pkg::PIE_TX_BIT];
  assign group_rx_irq_en          = periph_irq_enable_reg[buf_irq_pkg::PIE_RX_BIT];
  assign group_tx_irq_flag        = periph_irq_flag_reg[buf_irq_pkg::FLAG_TX_BIT];
  assign group_rx_irq_flag        = periph_irq_flag_reg[buf_irq_pkg::FLAG_RX_BIT];

  // Per-buffer qualification, one slice per buffer
  genvar gi;
  generate
    for (gi = 0; gi < buf_irq_pkg::NUM_TXB; gi++) begin : g_txb
      assign txb_hit[gi] = TXB_DONE[gi] & tx_buf_irq_en_bits[gi];
    end
    for (gi = 0; gi < buf_irq_pkg::NUM_BUF; gi++) begin : g_buf
      // Buffer enable; dedicated receive buffers never transmit
      assign buf_tx_hit[gi] = BUF_EVENT[gi] & buffer_irq_enable_reg[gi] & BUF_IS_TX[gi]
                              & (gi >= 2);
      assign buf_rx_hit[gi] = BUF_EVENT[gi] & buffer_irq_enable_reg[gi]
                              & ~(BUF_IS_TX[gi] & (gi >= 2));
    end
  endgenerate

  assign tx_event = enhanced & ((|txb_hit) | (|buf_tx_hit));
  assign rx_event = enhanced & (|buf_rx_hit);

  // ====================================================================
  // Bus decode and next state
  assign access = WB_CYC_I & WB_STB_I & ~ack_reg;
  assign wr     = access & WB_WE_I & WB_SEL_I[0];
  assign clr_tx_flag = wr && (WB_ADR_I == buf_irq_pkg::FLAG_ADDR)
                       && !WB_DAT_I[buf_irq_pkg::FLAG_TX_BIT];
  assign clr_rx_flag = wr && (WB_ADR_I == buf_irq_pkg::FLAG_ADDR)
                       && !WB_DAT_I[buf_irq_pkg::FLAG_RX_BIT];

  // Register next values; hardware set wins over software clear
  always_comb begin
    tx_buffer_irq_enable_next = tx_buffer_irq_enable_reg;
    buffer_irq_enable_next    = buffer_irq_enable_reg;
    periph_irq_enable_next    = periph_irq_enable_reg;
    periph_irq_flag_next      = periph_irq_flag_reg;
    mode_next                 = mode_reg;
    stat_next                 = stat_reg;
    mask_next                 = mask_reg;
    ack_next                  = access;
    dat_next                  = 32'h0000_0000;
    if (wr) begin
      case (WB_ADR_I)
        buf_irq_pkg::TXB_EN_ADDR: if (enhanced) begin
          tx_buffer_irq_enable_next = WB_DAT_I[7:0] & buf_irq_pkg::TXB_EN_MASK;
        end
        buf_irq_pkg::BUF_EN_ADDR: if (enhanced) begin
          buffer_irq_enable_next = WB_DAT_I[7:0];
        end
        buf_irq_pkg::PIE_ADDR:  periph_irq_enable_next = WB_DAT_I[7:0] & buf_irq_pkg::PIE_MASK;
        buf_irq_pkg::MODE_ADDR: mode_next = WB_DAT_I[1:0];
        buf_irq_pkg::STAT_ADDR: stat_next = stat_reg & ~WB_DAT_I[1:0];
        buf_irq_pkg::MASK_ADDR: mask_next = WB_DAT_I[1:0];
        default: ;
      endcase
    end
    // Software may clear a flag by writing zero to it
    if (clr_tx_flag) periph_irq_flag_next[buf_irq_pkg::FLAG_TX_BIT] = 1'b0;
    if (clr_rx_flag) periph_irq_flag_next[buf_irq_pkg::FLAG_RX_BIT] = 1'b0;
    if (tx_event) periph_irq_flag_next[buf_irq_pkg::FLAG_TX_BIT] = 1'b1;
    if (rx_event) periph_irq_flag_next[buf_irq_pkg::FLAG_RX_BIT] = 1'b1;
    stat_next = stat_next | {rx_event, tx_event};
    if (access && !WB_WE_I) begin
      case (WB_ADR_I)
        buf_irq_pkg::TXB_EN_ADDR: dat_next[7:0] = enhanced ? tx_buffer_irq_enable_reg : 8'h00;
        buf_irq_pkg::BUF_EN_ADDR: dat_next[7:0] = enhanced ? buffer_irq_enable_reg : 8'h00;
        buf_irq_pkg::PIE_ADDR:    dat_next[7:0] = periph_irq_enable_reg;
        buf_irq_pkg::FLAG_ADDR:   dat_next[7:0] = periph_irq_flag_reg;
        buf_irq_pkg::MODE_ADDR:   dat_next[1:0] = mode_reg;
        buf_irq_pkg::STAT_ADDR:   dat_next[1:0] = stat_reg;
        buf_irq_pkg::MASK_ADDR:   dat_next[1:0] = mask_reg;
        default:                  dat_next = 32'h0000_0000;
      endcase
    end
  end

  // Registers; clock enable freezes everything
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      tx_buffer_irq_enable_reg <= buf_irq_pkg::REG_RESET;
      buffer_irq_enable_reg    <= buf_irq_pkg::REG_RESET;
      periph_irq_enable_reg    <= buf_irq_pkg::REG_RESET;
      periph_irq_flag_reg      <= buf_irq_pkg::REG_RESET;
      mode_reg                 <= buf_irq_pkg::MODE_RESET;
      stat_reg                 <= buf_irq_pkg::STAT_RESET;
      mask_reg                 <= buf_irq_pkg::STAT_RESET;
      ack_reg                  <= 1'b0;
      dat_reg                  <= 32'h0000_0000;
    end else if (CE) begin
      tx_buffer_irq_enable_reg <= tx_buffer_irq_enable_next;
      buffer_irq_enable_reg    <= buffer_irq_enable_next;
      periph_irq_enable_reg    <= periph_irq_enable_next;
      periph_irq_flag_reg      <= periph_irq_flag_next;
      mode_reg                 <= mode_next;
      stat_reg                 <= stat_next;
      mask_reg                 <= mask_next;
      ack_reg                  <= ack_next;
      dat_reg                  <= dat_next;
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = dat_reg;

  // ====================================================================
  // Interrupt outputs
  // Group enables gate delivery to the CPU
  assign CPU_IRQ = enhanced & ((group_tx_irq_flag & group_tx_irq_en)
                             | (group_rx_irq_flag & group_rx_irq_en));
  assign IRQ     = |(stat_reg & mask_reg);

  // ====================================================================
  // Checks
  // Enabled transmit completion seen while running
  sequence s_tx_done;
    CE && enhanced && (|(TXB_DONE & tx_buf_irq_en_bits));
  endsequence

  // Register read taken by the slave this cycle
  sequence s_read_req;
    CE && access && !WB_WE_I;
  endsequence

  // Enable register write stored this cycle
  sequence s_write_req;
    CE && enhanced && wr;
  endsequence

  AST_TX_FLAG_SET: assert property (@(posedge CLK) disable iff (RESET)
    s_tx_done |=> group_tx_irq_flag)
    else $error("Transmit flag not set after enabled completion");
  AST_RX_FLAG_SET: assert property (@(posedge CLK) disable iff (RESET)
    CE && rx_event |=> group_rx_irq_flag)
    else $error("Receive flag not set after enabled reception");
  AST_TXB_RESERVED: assert property (@(posedge CLK) disable iff (RESET)
    (tx_buffer_irq_enable_reg & ~buf_irq_pkg::TXB_EN_MASK) == 8'h00)
    else $error("Unimplemented transmit enable bit set");
  AST_LEGACY_SILENT: assert property (@(posedge CLK) disable iff (RESET)
    !enhanced |-> !CPU_IRQ && !tx_event && !rx_event)
    else $error("Interrupt in legacy mode");
  AST_TX_GATED: assert property (@(posedge CLK) disable iff (RESET)
    CPU_IRQ && !group_rx_irq_en |-> group_tx_irq_en && group_tx_irq_flag)
    else $error("Transmit interrupt without group enable");
  AST_GROUP_GATE: assert property (@(posedge CLK) disable iff (RESET)
    !group_tx_irq_en && !group_rx_irq_en |-> !CPU_IRQ)
    else $error("Interrupt with both group enables off");
  AST_TXB_EN_BIT: assert property (@(posedge CLK) disable iff (RESET)
    enhanced && TXB_DONE == 3'h1 && !tx_buffer_irq_enable_reg[2] && !(|buf_tx_hit)
    |-> !tx_event)
    else $error("Disabled transmit buffer 0 raised an event");
  AST_RX_DEDICATED: assert property (@(posedge CLK) disable iff (RESET)
    enhanced && BUF_EVENT[0] && dedicated_rx_irq_en_bits[0] |-> rx_event)
    else $error("Dedicated receive buffer 0 event lost");
  AST_PROG_BUF: assert property (@(posedge CLK) disable iff (RESET)
    enhanced && BUF_EVENT[7] && BUF_IS_TX[7] && prog_buf_irq_en_bits[5] |-> tx_event)
    else $error("Programmable buffer 5 transmit event lost");
  AST_WRITE_BUF: assert property (@(posedge CLK) disable iff (RESET)
    s_write_req ##0 (WB_ADR_I == buf_irq_pkg::BUF_EN_ADDR)
    |=> buffer_irq_enable_reg == $past(WB_DAT_I[7:0]))
    else $error("Buffer enable write not stored");
  // Single acknowledge; a frozen cycle may stretch it
  AST_ACK_ONE: assert property (@(posedge CLK) disable iff (RESET)
    CE && access |=> WB_ACK_O ##1 (!WB_ACK_O || !$past(CE)))
    else $error("Acknowledge not a single cycle");
  AST_REQ_FORM: assert property (@(posedge CLK) disable iff (RESET)
    CPU_IRQ |-> (group_tx_irq_flag || group_rx_irq_flag))
    else $error("Request without group flag");
  // Transmit enable write keeps three bits
  AST_TXB_WRITE: assert property (@(posedge CLK) disable iff (RESET)
    s_write_req ##0 (WB_ADR_I == buf_irq_pkg::TXB_EN_ADDR)
    |=> tx_buffer_irq_enable_reg == ($past(WB_DAT_I[7:0]) & buf_irq_pkg::TXB_EN_MASK))
    else $error("Transmit enable write not stored");
  // Legacy writes ignored; stored values survive a mode change
  AST_LEGACY_WRITE: assert property (@(posedge CLK) disable iff (RESET)
    CE && wr && !enhanced
    |=> $stable(tx_buffer_irq_enable_reg) && $stable(buffer_irq_enable_reg))
    else $error("Enable register changed in legacy mode");
  AST_LEGACY_READ: assert property (@(posedge CLK) disable iff (RESET)
    s_read_req ##0 (!enhanced && (WB_ADR_I == buf_irq_pkg::TXB_EN_ADDR
                                  || WB_ADR_I == buf_irq_pkg::BUF_EN_ADDR))
    |=> WB_DAT_O == 32'h0000_0000)
    else $error("Enable register visible in legacy mode");
  AST_TXB_READ: assert property (@(posedge CLK) disable iff (RESET)
    s_read_req ##0 (WB_ADR_I == buf_irq_pkg::TXB_EN_ADDR)
    |=> (WB_DAT_O & ~{24'h000000, buf_irq_pkg::TXB_EN_MASK}) == 32'h0000_0000)
    else $error("Unimplemented transmit enable bit read as one");
  AST_TX_DELIVER: assert property (@(posedge CLK) disable iff (RESET)
    enhanced && group_tx_irq_flag && group_tx_irq_en |-> CPU_IRQ)
    else $error("Enabled transmit interrupt not delivered");
  AST_RX_DELIVER: assert property (@(posedge CLK) disable iff (RESET)
    enhanced && group_rx_irq_flag && group_rx_irq_en |-> CPU_IRQ)
    else $error("Enabled receive interrupt not delivered");
  AST_RX_GATED: assert property (@(posedge CLK) disable iff (RESET)
    CPU_IRQ && !group_tx_irq_en |-> group_rx_irq_en && group_rx_irq_flag)
    else $error("Receive interrupt without group enable");
  AST_TX_FLAG_CAUSE: assert property (@(posedge CLK) disable iff (RESET)
    CE && !group_tx_irq_flag && !tx_event |=> !group_tx_irq_flag)
    else $error("Transmit flag set without an event");
  AST_RX_FLAG_CAUSE: assert property (@(posedge CLK) disable iff (RESET)
    CE && !group_rx_irq_flag && !rx_event |=> !group_rx_irq_flag)
    else $error("Receive flag set without an event");
  AST_TX_FLAG_HOLD: assert property (@(posedge CLK) disable iff (RESET)
    CE && group_tx_irq_flag && !clr_tx_flag |=> group_tx_irq_flag)
    else $error("Transmit flag dropped without a clear");
  AST_RX_FLAG_CLEAR: assert property (@(posedge CLK) disable iff (RESET)
    CE && clr_rx_flag && !rx_event |=> !group_rx_irq_flag)
    else $error("Receive flag not cleared by software");
  AST_DEDICATED_RX_ONLY: assert property (@(posedge CLK) disable iff (RESET)
    TXB_DONE == 3'h0 && BUF_EVENT[7:2] == 6'h00 |-> !tx_event)
    else $error("Dedicated receive buffer raised a transmit event");
  AST_PROG_RX: assert property (@(posedge CLK) disable iff (RESET)
    enhanced && BUF_EVENT[2] && !BUF_IS_TX[2] && prog_buf_irq_en_bits[0] |-> rx_event)
    else $error("Programmable buffer 0 receive event lost");
  AST_RESET_CLEAR: assert property (@(posedge CLK)
    RESET && $past(RESET)
    |-> tx_buffer_irq_enable_reg == buf_irq_pkg::REG_RESET
        && buffer_irq_enable_reg == buf_irq_pkg::REG_RESET)
    else $error("Enable register not cleared in reset");
  // Clock enable low freezes flags and status
  AST_CE_FREEZE: assert property (@(posedge CLK) disable iff (RESET)
    !CE |=> $stable(periph_irq_flag_reg) && $stable(stat_reg))
    else $error("Flag state moved while clock enable was low");

endmodule

// ==== testbench/buf_event_model.sv ====
// Behavioural model of the message buffer logic that raises per-buffer events
`timescale 1ns/1ps
module buf_event_model (
  input  wire logic       clk,
  output logic      [2:0] txb_done,
  output logic      [7:0] buf_event,
  output logic      [7:0] buf_is_tx
);
  // Idle: no buffer reports anything between events
  initial begin
    txb_done  = 3'h0;
    buf_event = 8'h00;
    buf_is_tx = 8'h00;
  end
  // One-cycle pulse; direction flips after so a stale qualifier is never trusted
  task automatic fire(input logic [2:0] tx, input logic [7:0] ev, input logic [7:0] istx);
    @(posedge clk);
    txb_done  <= tx;
    buf_event <= ev;
    buf_is_tx <= istx;
    @(posedge clk);
    txb_done  <= 3'h0;
    buf_event <= 8'h00;
    buf_is_tx <= ~istx;
  endtask
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the buffer interrupt gating block
`timescale 1ns/1ps
module tb_top;
  logic        clk, reset, ce, cyc, stb, we, ack, cpu_irq, irq;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, rd;
  logic [2:0]  txb_done;
  logic [7:0]  buf_event, buf_is_tx;
  int          n_fail, checks_done;
  // ==========================================
  // Design and buffer model
  buf_irq_gate dut (
    .CLK(clk), .RESET(reset), .CE(ce), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .TXB_DONE(txb_done),
    .BUF_EVENT(buf_event), .BUF_IS_TX(buf_is_tx), .CPU_IRQ(cpu_irq), .IRQ(irq)
  );
  buf_event_model bm (
    .clk(clk), .txb_done(txb_done), .buf_event(buf_event), .buf_is_tx(buf_is_tx)
  );
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ==========================================
  // Compare, bus and report tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Classic cycle: held until ack is sampled high, released at that edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    chk("ack", {31'h0, ack}, 32'h1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), rd, {24'h000000, exp});
  endtask
  // Fire an event, read the group flags, then clear flags and status
  task automatic evchk(input logic [2:0] t, input logic [7:0] b, input logic [7:0] x,
                       input logic [7:0] exp);
    bm.fire(t, b, x);
    rchk(buf_irq_pkg::FLAG_ADDR, exp);
    wb(1'b1, buf_irq_pkg::FLAG_ADDR, 8'h00);
    wb(1'b1, buf_irq_pkg::STAT_ADDR, 8'h03);
  endtask
  // Levels are combinational from registers, so look once they settle
  task automatic lvl(input logic c, input logic i);
    @(negedge clk);
    chk("cpu_irq", {31'h0, cpu_irq}, {31'h0, c});
    chk("irq", {31'h0, irq}, {31'h0, i});
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Watchdog: the sequence needs about five hundred cycles
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
  // ==========================================
  // Test sequence
  initial begin
    {reset, ce, sel} = {1'b1, 1'b1, 4'hF};
    {cyc, stb, we, adr, wdat} = '0;
    {n_fail, checks_done} = '0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a < 32; a += 4) rchk(8'(a), 8'h00);
    wb(1'b1, buf_irq_pkg::TXB_EN_ADDR, 8'hFF);
    wb(1'b1, buf_irq_pkg::BUF_EN_ADDR, 8'hFF);
    evchk(3'h7, 8'hFF, 8'hFF, 8'h00);
    wb(1'b1, buf_irq_pkg::MODE_ADDR, 8'h01);
    rchk(buf_irq_pkg::TXB_EN_ADDR, 8'h00);
    wb(1'b1, buf_irq_pkg::TXB_EN_ADDR, 8'hFF);
    rchk(buf_irq_pkg::TXB_EN_ADDR, 8'h1C);
    wb(1'b1, buf_irq_pkg::BUF_EN_ADDR, 8'hA5);
    rchk(buf_irq_pkg::BUF_EN_ADDR, 8'hA5);
    // One transmit buffer enabled at a time, both enhanced modes
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, buf_irq_pkg::MODE_ADDR, (i == 1) ? 8'h02 : 8'h01);
      wb(1'b1, buf_irq_pkg::BUF_EN_ADDR, 8'h00);
      wb(1'b1, buf_irq_pkg::TXB_EN_ADDR, 8'h04 << i);
      evchk(~(3'h1 << i), 8'h00, 8'h00, 8'h00);
      evchk(3'h1 << i, 8'h00, 8'h00, 8'h10);
    end
    // The loop leaves only transmit buffer 2 enabled
    bm.fire(3'h4, 8'h00, 8'h00);
    lvl(1'b0, 1'b0);
    rchk(buf_irq_pkg::STAT_ADDR, 8'h01);
    wb(1'b1, buf_irq_pkg::PIE_ADDR, 8'h02);
    lvl(1'b0, 1'b0);
    wb(1'b1, buf_irq_pkg::PIE_ADDR, 8'h10);
    wb(1'b1, buf_irq_pkg::MASK_ADDR, 8'h02);
    lvl(1'b1, 1'b0);
    wb(1'b1, buf_irq_pkg::MASK_ADDR, 8'h01);
    lvl(1'b1, 1'b1);
    wb(1'b1, buf_irq_pkg::STAT_ADDR, 8'h01);
    wb(1'b1, buf_irq_pkg::FLAG_ADDR, 8'h00);
    lvl(1'b0, 1'b0);
    wb(1'b1, buf_irq_pkg::TXB_EN_ADDR, 8'h00);
    // Each buffer enable bit alone; others fire and must stay silent
    for (int j = 0; j < 8; j++) begin
      wb(1'b1, buf_irq_pkg::BUF_EN_ADDR, 8'h01 << j);
      evchk(3'h0, ~(8'h01 << j), 8'hFF, 8'h00);
      evchk(3'h0, 8'h01 << j, 8'hFF, (j > 1) ? 8'h10 : 8'h02);
      if (j > 1) evchk(3'h0, 8'h01 << j, 8'h00, 8'h02);
    end
    wb(1'b1, buf_irq_pkg::BUF_EN_ADDR, 8'h01);
    wb(1'b1, buf_irq_pkg::PIE_ADDR, 8'h00);
    bm.fire(3'h0, 8'h01, 8'h00);
    lvl(1'b0, 1'b0);
    wb(1'b1, buf_irq_pkg::PIE_ADDR, 8'h02);
    lvl(1'b1, 1'b0);
    wb(1'b1, buf_irq_pkg::MODE_ADDR, 8'h00);
    lvl(1'b0, 1'b0);
    rchk(buf_irq_pkg::BUF_EN_ADDR, 8'h00);
    // Mode code 3 counts as legacy
    wb(1'b1, buf_irq_pkg::MODE_ADDR, 8'h03);
    rchk(buf_irq_pkg::BUF_EN_ADDR, 8'h00);
    // Clock enable low: an enabled reception must not reach the flag
    wb(1'b1, buf_irq_pkg::MODE_ADDR, 8'h01);
    wb(1'b1, buf_irq_pkg::FLAG_ADDR, 8'h00);
    ce <= 1'b0;
    bm.fire(3'h0, 8'h01, 8'h00);
    ce <= 1'b1;
    rchk(buf_irq_pkg::FLAG_ADDR, 8'h00);
    stop_test();
  end
endmodule
